// >>> verilog/padc_pkg.sv
// package of constants for the pipelined converter output port
// assumes one system clock of 50 MHz and an Avalon-MM register slave
package padc_pkg;
    localparam int          SAMPLE_W       = 11;
    localparam int          PIPE_DEPTH     = 5;
    localparam int          ADDR_W         = 4;
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STATUS     = 4'h4;
    localparam logic [3:0]  REG_IRQ_STAT   = 4'h8;
    localparam logic [3:0]  REG_IRQ_MASK   = 4'hC;
    localparam int          CTRL_SLEEP     = 0;
    localparam int          CTRL_OE_N      = 1;
    localparam int          CTRL_FMT_LO    = 2;
    localparam int          STAT_NORMAL    = 0;
    localparam int          STAT_NAP       = 1;
    localparam int          STAT_SLEEP     = 2;
    localparam int          STAT_DRIVE     = 3;
    localparam int          STAT_TWOS      = 4;
    localparam int          STAT_DCS       = 5;
    localparam int          IRQ_SAMPLE     = 0;
    localparam int          IRQ_RANGE      = 1;
    localparam int          IRQ_W          = 2;
    localparam logic [3:0]  CTRL_RESET     = 4'h2;
    localparam logic [31:0] BUS_UNMAPPED   = 32'h0000_0000;
    localparam logic [1:0]  FMT_OB_OFF     = 2'h0;
    localparam logic [1:0]  FMT_OB_ON      = 2'h1;
    localparam logic [1:0]  FMT_TC_ON      = 2'h2;
    localparam logic [1:0]  FMT_TC_OFF     = 2'h3;
    typedef enum logic [1:0] {
        PADC_RUN_ON  = 2'b00,
        PADC_RUN_OFF = 2'b01,
        PADC_NAP     = 2'b10,
        PADC_SLEEP   = 2'b11
    } padc_mode_type;
endpackage

// >>> verilog/padc_sync2.sv
// two flip-flop synchroniser for a level from outside the clock domain
// assumes a synchronous active high reset
`timescale 1ns/10ps
module padc_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // level in and out
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] sync_ff;
    logic [W-1:0] nxt_sync;

    always_comb begin
        nxt_meta = din;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign dout = sync_ff;
endmodule

// >>> verilog/padc_pipe.sv
// five stage sample pipeline advanced once per encode rising edge
// assumes the advance strobe is a one-cycle pulse on sys_clk
`timescale 1ns/10ps
module padc_pipe #(
    parameter int W     = 12,
    parameter int DEPTH = 5
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // stage control
    input  wire logic         advance,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage_ff [DEPTH];
    logic [W-1:0] nxt_stage [DEPTH];

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            nxt_stage[i] = stage_ff[i];
        end
        if (advance) begin
            nxt_stage[0] = din;
            for (int i = 1; i < DEPTH; i++) begin
                nxt_stage[i] = stage_ff[i-1];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (rst) begin
                stage_ff[i] <= '0;
            end else begin
                stage_ff[i] <= nxt_stage[i];
            end
        end
    end

    assign dout = stage_ff[DEPTH-1];
endmodule

// >>> verilog/padc_port.sv
// digital output port of an 11-bit pipelined sampling converter
// assumes encode clock pins and analog result arrive asynchronously;
// software controls modes over Avalon-MM; output drivers resolved outside
`timescale 1ns/10ps

// Function
// RULE1: sample taken on encode low-to-high edge
// RULE2: encode high when true above complement
// RULE3: result appears five encode cycles later
// RULE4: sleep low, enable low: convert, drive
// RULE5: sleep low, enable high: convert, float
// RULE6: sleep high, enable low: nap, float
// RULE7: both high: sleep mode, outputs float
// RULE8: receiver latches on strobe falling edge
// RULE9: eleven bit word, top bit is MSB
// RULE10: range flag high on over/underflow
// RULE11: format select sets coding and stabilizer
// RULE12: two's complement by inverting MSB only
// RULE13: receiver drops first five words after start
module padc_port import padc_pkg::*; (
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst,
    // encode clock pins
    input  wire logic                sample_clock_true,
    input  wire logic                sample_clock_comp,
    // analog core result, offset binary
    input  wire logic [SAMPLE_W-1:0] core_value,
    input  wire logic                core_range,
    // output pins
    output logic      [SAMPLE_W-1:0] sample_word,
    output logic      [SAMPLE_W-1:0] sample_word_oe,
    output logic                     range_exceeded_flag,
    output logic                     range_exceeded_flag_oe,
    output logic                     data_valid_strobe,
    output logic                     data_valid_strobe_oe,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    // interrupt
    output logic                     irq
);
    logic                trueSync;
    logic                compSync;
    logic [SAMPLE_W:0]   coreSync;
    logic                encHigh;
    logic                encPrev_ff;
    logic                nxt_encPrev;
    logic                encRise;
    logic                encFall;
    logic [SAMPLE_W:0]   pipeOut;
    padc_mode_type       mode;
    logic                converting;
    logic                drive;
    logic                twos;
    logic                dcs;
    logic [3:0]          ctrl_ff;
    logic [3:0]          nxt_ctrl;
    logic [IRQ_W-1:0]    irqStat_ff;
    logic [IRQ_W-1:0]    nxt_irqStat;
    logic [IRQ_W-1:0]    irqMask_ff;
    logic [IRQ_W-1:0]    nxt_irqMask;
    logic                irq_ff;
    logic                nxt_irq;
    logic [31:0]         rdata_ff;
    logic [31:0]         nxt_rdata;
    logic                ack_ff;
    logic                nxt_ack;
    logic                waitReq_ff;
    logic                nxt_wait;
    logic [SAMPLE_W-1:0] word_ff;
    logic [SAMPLE_W-1:0] nxt_word;
    logic                flag_ff;
    logic                nxt_flag;
    logic                strobe_ff;
    logic                nxt_strobe;
    logic                oe_ff;
    logic                nxt_oe;
    logic [SAMPLE_W-1:0] codedWord;
    logic [31:0]         statusWord;

    // pin synchronisers
    padc_sync2 #(.W(2)) u_enc_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     ({sample_clock_true, sample_clock_comp}),
        .dout    ({trueSync, compSync})
    );

    padc_sync2 #(.W(SAMPLE_W + 1)) u_core_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     ({core_range, core_value}),
        .dout    (coreSync)
    );

    // encode phase and edges
    always_comb begin
        encHigh     = trueSync & ~compSync; // RULE2
        nxt_encPrev = encHigh;
        encRise     = encHigh & ~encPrev_ff; // RULE1
        encFall     = ~encHigh & encPrev_ff;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            encPrev_ff <= 1'b0;
        end else begin
            encPrev_ff <= nxt_encPrev;
        end
    end

    // mode decode from sleep select and active-low enable
    always_comb begin
        mode = padc_mode_type'({ctrl_ff[CTRL_SLEEP], ctrl_ff[CTRL_OE_N]});
        converting = 1'b0;
        drive      = 1'b0;
        case (mode)
            PADC_RUN_ON: begin
                converting = 1'b1; // RULE4
                drive      = 1'b1; // RULE4
            end
            PADC_RUN_OFF: begin
                converting = 1'b1; // RULE5
            end
            PADC_NAP: begin
                converting = 1'b0; // RULE6
            end
            PADC_SLEEP: begin
                converting = 1'b0; // RULE7
            end
            default: begin
                converting = 1'b0;
            end
        endcase
    end

    // format select
    always_comb begin
        twos = 1'b0;
        dcs  = 1'b0;
        case (ctrl_ff[CTRL_FMT_LO +: 2])
            FMT_OB_OFF: begin
                twos = 1'b0; // RULE11
                dcs  = 1'b0;
            end
            FMT_OB_ON: begin
                twos = 1'b0; // RULE11
                dcs  = 1'b1;
            end
            FMT_TC_ON: begin
                twos = 1'b1; // RULE11
                dcs  = 1'b1;
            end
            FMT_TC_OFF: begin
                twos = 1'b1; // RULE11
                dcs  = 1'b0;
            end
            default: begin
                twos = 1'b0;
                dcs  = 1'b0;
            end
        endcase
    end

    // sample pipeline, advanced on encode rise
    padc_pipe #(.W(SAMPLE_W + 1), .DEPTH(PIPE_DEPTH)) u_pipe (
        .sys_clk (sys_clk),
        .rst     (rst),
        .advance (encRise & converting), // RULE3
        .din     (coreSync), // RULE1
        .dout    (pipeOut)
    );

    // output stage: data and strobe change on encode rise, strobe falls on encode fall
    always_comb begin
        codedWord = pipeOut[SAMPLE_W-1:0];
        if (twos) begin
            codedWord[SAMPLE_W-1] = ~pipeOut[SAMPLE_W-1]; // RULE12
        end
        nxt_word   = word_ff;
        nxt_flag   = flag_ff;
        nxt_strobe = strobe_ff;
        nxt_oe     = drive; // RULE5
        if (encRise & converting) begin
            nxt_word   = codedWord; // RULE9
            nxt_flag   = pipeOut[SAMPLE_W]; // RULE10
            nxt_strobe = 1'b1;
        end else if (encFall | ~converting) begin
            nxt_strobe = 1'b0; // RULE8
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            word_ff   <= '0;
            flag_ff   <= 1'b0;
            strobe_ff <= 1'b0;
            oe_ff     <= 1'b0;
        end else begin
            word_ff   <= nxt_word;
            flag_ff   <= nxt_flag;
            strobe_ff <= nxt_strobe;
            oe_ff     <= nxt_oe;
        end
    end

    assign sample_word            = word_ff;
    assign sample_word_oe         = {SAMPLE_W{oe_ff}};
    assign range_exceeded_flag    = flag_ff;
    assign range_exceeded_flag_oe = oe_ff;
    assign data_valid_strobe      = strobe_ff;
    assign data_valid_strobe_oe   = oe_ff;

    // register bus, interrupts
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[STAT_NORMAL] = converting;
        statusWord[STAT_NAP]    = (mode == PADC_NAP);
        statusWord[STAT_SLEEP]  = (mode == PADC_SLEEP);
        statusWord[STAT_DRIVE]  = oe_ff;
        statusWord[STAT_TWOS]   = twos;
        statusWord[STAT_DCS]    = dcs;
        nxt_ack     = (avs_read | avs_write) & ~ack_ff;
        nxt_wait    = ~nxt_ack;
        nxt_rdata   = rdata_ff;
        nxt_ctrl    = ctrl_ff;
        nxt_irqMask = irqMask_ff;
        nxt_irqStat = irqStat_ff;
        // write lands on the edge that sees waitrequest low
        if (ack_ff & avs_write) begin
            case (avs_address)
                REG_CTRL:     nxt_ctrl    = avs_writedata[3:0];
                REG_IRQ_STAT: nxt_irqStat = irqStat_ff & ~avs_writedata[IRQ_W-1:0];
                REG_IRQ_MASK: nxt_irqMask = avs_writedata[IRQ_W-1:0];
                default:      nxt_ctrl    = ctrl_ff;
            endcase
        end
        if (nxt_ack & avs_read) begin
            case (avs_address)
                REG_CTRL:     nxt_rdata = {28'h0000000, ctrl_ff};
                REG_STATUS:   nxt_rdata = statusWord;
                REG_IRQ_STAT: nxt_rdata = {30'h00000000, irqStat_ff};
                REG_IRQ_MASK: nxt_rdata = {30'h00000000, irqMask_ff};
                default:      nxt_rdata = BUS_UNMAPPED;
            endcase
        end
        // hardware set wins over software clear
        if (encRise & converting) begin
            nxt_irqStat[IRQ_SAMPLE] = 1'b1;
            if (pipeOut[SAMPLE_W]) begin
                nxt_irqStat[IRQ_RANGE] = 1'b1;
            end
        end
        nxt_irq = |(irqStat_ff & irqMask_ff);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_ff    <= CTRL_RESET;
            irqStat_ff <= '0;
            irqMask_ff <= '0;
            irq_ff     <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            ack_ff     <= 1'b0;
            waitReq_ff <= 1'b1;
        end else begin
            ctrl_ff    <= nxt_ctrl;
            irqStat_ff <= nxt_irqStat;
            irqMask_ff <= nxt_irqMask;
            irq_ff     <= nxt_irq;
            rdata_ff   <= nxt_rdata;
            ack_ff     <= nxt_ack;
            waitReq_ff <= nxt_wait;
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = waitReq_ff;
    assign irq             = irq_ff;

    // checks
    AST_SLEEP_FLOAT: assert property (@(posedge sys_clk) disable iff (rst) // RULE7
        (mode == PADC_SLEEP) |=> !data_valid_strobe_oe)
        else $error("outputs driven in sleep");
    AST_NAP_FLOAT: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
        (mode == PADC_NAP) |=> !range_exceeded_flag_oe)
        else $error("outputs driven in nap");
    AST_RUN_DRIVE: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
        (mode == PADC_RUN_ON) |=> sample_word_oe == {SAMPLE_W{1'b1}})
        else $error("outputs not driven in run");
    AST_RUN_FLOAT: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
        (mode == PADC_RUN_OFF) && encRise |=> data_valid_strobe && !data_valid_strobe_oe)
        else $error("no conversion with outputs floating");
    AST_EDGE_PHASE: assert property (@(posedge sys_clk) disable iff (rst) // RULE2
        encRise |-> $past(trueSync & ~compSync) == 1'b0)
        else $error("rise without prior low phase");
    AST_STROBE_RISE: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
        $rose(data_valid_strobe) |-> $past(encRise))
        else $error("strobe rose without encode rise");
    AST_FLAG: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
        encRise && converting |=> range_exceeded_flag == $past(pipeOut[SAMPLE_W]))
        else $error("range flag mismatch");
    AST_TWOS: assert property (@(posedge sys_clk) disable iff (rst) // RULE12
        encRise && converting && twos |=> sample_word == {~$past(pipeOut[SAMPLE_W-1]),
            $past(pipeOut[SAMPLE_W-2:0])})
        else $error("twos complement coding wrong");
    AST_BINARY: assert property (@(posedge sys_clk) disable iff (rst) // RULE9
        encRise && converting && !twos |=> sample_word == $past(pipeOut[SAMPLE_W-1:0]))
        else $error("offset binary word wrong");
    AST_FMT: assert property (@(posedge sys_clk) disable iff (rst) // RULE11
        twos == ctrl_ff[CTRL_FMT_LO + 1] && dcs == (ctrl_ff[CTRL_FMT_LO +: 2] inside {2'h1, 2'h2}))
        else $error("format decode wrong");
    AST_HALT: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
        !converting |=> !data_valid_strobe)
        else $error("strobe while not converting");
    COV_RUN: cover property (@(posedge sys_clk) disable iff (rst)
        mode == PADC_RUN_ON && $rose(data_valid_strobe));
    COV_RANGE: cover property (@(posedge sys_clk) disable iff (rst) $rose(range_exceeded_flag));
    COV_IRQ: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq));
    COV_NAP: cover property (@(posedge sys_clk) disable iff (rst) mode == PADC_NAP);
    COV_TWOS: cover property (@(posedge sys_clk) disable iff (rst)
        twos && $rose(data_valid_strobe));
    AST_WAIT_ONE: assert property (@(posedge sys_clk) disable iff (rst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_IRQ_LEVEL: assert property (@(posedge sys_clk) disable iff (rst)
        irq == $past(|(irqStat_ff & irqMask_ff)))
        else $error("interrupt level does not follow masked status");
    AST_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // RULE8
        $fell(data_valid_strobe) |-> $stable(sample_word) && $stable(range_exceeded_flag))
        else $error("word changed as strobe fell");
    AST_PIPE_HALT: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
        !converting |=> $stable(pipeOut))
        else $error("pipeline moved while halted");
    AST_SAMPLE_SET: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
        encRise && converting |=> irqStat_ff[IRQ_SAMPLE])
        else $error("sample event not flagged");
    AST_RANGE_SET: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
        encRise && converting && pipeOut[SAMPLE_W]
            |=> irqStat_ff[IRQ_RANGE] && range_exceeded_flag)
        else $error("range event not flagged");
endmodule

// >>> bench/padc_rx_model.sv
// far side model: encode clock source and receiving latch
// assumes resolved output pins from the bench and the 50 MHz sys_clk
`timescale 1ns/10ps
module padc_rx_model import padc_pkg::*; (
    // clock and control
    input  wire logic                sys_clk,
    input  wire logic                run,
    // encode pins and fall count
    output logic                     sample_clock_true,
    output logic                     sample_clock_comp,
    output int                       nFall,
    // resolved output pins
    input  wire logic [SAMPLE_W-1:0] pinWord,
    input  wire logic                pinFlag,
    input  wire logic                pinStrobe,
    // kept capture
    output logic [SAMPLE_W-1:0]      capWord,
    output logic                     capFlag,
    output logic                     capNew
);
    logic strobeQ = 1'b0;
    logic runQ    = 1'b0;
    int   dropCnt = 0;

    // 160 ns encode clock, still low between frames
    initial begin
        sample_clock_true = 1'b0;
        sample_clock_comp = 1'b1;
        nFall = 0;
        #3;
        forever begin
            if (run) begin
                sample_clock_true = 1'b1;
                sample_clock_comp = 1'b0;
                #80;
                sample_clock_true = 1'b0;
                sample_clock_comp = 1'b1;
                nFall++;
                #80;
            end else begin
                #7;
            end
        end
    end

    // latch on strobe fall, drop pipeline fill words
    always @(posedge sys_clk) begin
        strobeQ <= pinStrobe;
        runQ <= run;
        capNew <= 1'b0;
        if (run && !runQ) begin
            dropCnt <= 0;
        end else if (strobeQ === 1'b1 && pinStrobe === 1'b0) begin
            if (dropCnt < PIPE_DEPTH) begin
                dropCnt <= dropCnt + 1;
            end else begin
                capWord <= pinWord;
                capFlag <= pinFlag;
                capNew <= 1'b1;
            end
        end
    end
endmodule

// >>> bench/tb.sv
// bench: bus tasks, mode, format and interrupt scenarios
// assumes padc_port and padc_rx_model, 50 MHz sys_clk
`timescale 1ns/10ps
module tb import padc_pkg::*;;
    logic                sys_clk = 1'b0;
    logic                rst = 1'b1;
    logic                run = 1'b0;
    logic [SAMPLE_W-1:0] core_value = 11'h000;
    logic                core_range = 1'b0;
    logic [ADDR_W-1:0]   avs_address = 4'h0;
    logic                avs_read = 1'b0;
    logic                avs_write = 1'b0;
    logic [31:0]         avs_writedata = 32'h0;
    logic [SAMPLE_W-1:0] sample_word, sample_word_oe, pinWord, capWord;
    logic                range_exceeded_flag, range_exceeded_flag_oe, pinFlag, capFlag;
    logic                data_valid_strobe, data_valid_strobe_oe, pinStrobe, capNew;
    logic [31:0]         avs_readdata, rd;
    logic                avs_waitrequest, irq, sample_clock_true, sample_clock_comp;
    logic [SAMPLE_W-1:0] xorMask = 11'h000;
    int                  nFall, base = 0, idx = 0, n_fail = 0, compares = 0;

    always #10 sys_clk = ~sys_clk;

    assign pinWord   = sample_word_oe[0] ? sample_word : 'z;
    assign pinFlag   = range_exceeded_flag_oe ? range_exceeded_flag : 1'bz;
    assign pinStrobe = data_valid_strobe_oe ? data_valid_strobe : 1'bz;

    padc_port DUT (.sys_clk(sys_clk), .rst(rst), .sample_clock_true(sample_clock_true),
        .sample_clock_comp(sample_clock_comp), .core_value(core_value),
        .core_range(core_range), .sample_word(sample_word), .sample_word_oe(sample_word_oe),
        .range_exceeded_flag(range_exceeded_flag),
        .range_exceeded_flag_oe(range_exceeded_flag_oe),
        .data_valid_strobe(data_valid_strobe), .data_valid_strobe_oe(data_valid_strobe_oe),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq));

    padc_rx_model rx (.sys_clk(sys_clk), .run(run), .sample_clock_true(sample_clock_true),
        .sample_clock_comp(sample_clock_comp), .nFall(nFall), .pinWord(pinWord),
        .pinFlag(pinFlag), .pinStrobe(pinStrobe), .capWord(capWord), .capFlag(capFlag),
        .capNew(capNew));

    // analog value and range for the sample taken at rise i
    function automatic logic [11:0] expv(input int i);
        expv = {1'((i % 5) == 2), 11'(i) * 11'h125 + 11'h2AB};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("counts: compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) n_fail++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic irqIs(input logic b);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'(b));
    endtask

    // run the encode clock until n words are kept, or 80 cycles when none
    task automatic seg(input int n);
        int k = 0;
        base = nFall;
        idx = 0;
        @(posedge sys_clk);
        run <= 1'b1;
        while ((n > 0 ? idx < n : k < 80) && k < 600) begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 600) n_fail++;
        run <= 1'b0;
        repeat (30) @(posedge sys_clk);
    endtask

    // c holds format, output enable_n and sleep select
    task automatic mode(input logic [3:0] c);
        logic s, o;
        logic [1:0] f;
        s = c[0];
        o = c[1];
        f = c[3:2];
        bus(1'b1, REG_CTRL, {28'h0, c});
        rdc(REG_STATUS, {26'h0, f == 2'h1 || f == 2'h2, f[1], !s & !o, s & o, s & !o, !s});
        chk(32'({sample_word_oe, range_exceeded_flag_oe, data_valid_strobe_oe}), 32'({13{!s & !o}}));
        xorMask = f[1] ? 11'h400 : 11'h000;
        bus(1'b1, REG_IRQ_STAT, 32'h3);
        seg((s | o) ? 0 : 7);
        bus(1'b0, REG_IRQ_STAT, 32'h0);
        chk(32'(rd[0]), 32'(!s));
    endtask

    always @(posedge sys_clk) begin
        {core_range, core_value} <= expv(nFall);
        if (capNew) begin
            chk(32'({capFlag, capWord}), 32'(expv(base + idx) ^ {1'b0, xorMask}));
            idx = idx + 1;
        end
    end

    initial begin
        #300000;
        n_fail++;
        stop_test;
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        chk(32'({avs_waitrequest, irq, data_valid_strobe_oe, sample_word_oe}), 32'h2000);
        @(posedge sys_clk);
        rst <= 1'b0;
        rdc(REG_CTRL, {28'h0, CTRL_RESET});
        rdc(REG_IRQ_STAT, 32'h0);
        rdc(REG_IRQ_MASK, 32'h0);
        rdc(4'h2, BUS_UNMAPPED);
        bus(1'b1, REG_STATUS, 32'hFF);
        rdc(REG_STATUS, 32'h1);
        for (int m = 0; m < 4; m++) mode({2'h0, 2'(m)});
        for (int f = 0; f < 4; f++) mode({2'(f), 2'h0});
        bus(1'b1, REG_IRQ_STAT, 32'h3);
        seg(7);
        rdc(REG_IRQ_STAT, 32'h3);
        irqIs(1'b0);
        bus(1'b1, REG_IRQ_MASK, 32'h2);
        irqIs(1'b1);
        bus(1'b1, REG_IRQ_STAT, 32'h2);
        rdc(REG_IRQ_STAT, 32'h1);
        irqIs(1'b0);
        bus(1'b1, REG_IRQ_MASK, 32'h1);
        irqIs(1'b1);
        bus(1'b1, REG_IRQ_STAT, 32'h1);
        irqIs(1'b0);
        stop_test;
    end
endmodule
